// >>> src/eep_map.svh
// Purpose: Constants for the two-wire serial EEPROM slave.
// Assumes: 40 MHz mclk; 512-byte array, 8-byte pages.
// Notes: Times in ns; cycle counts derived in the top module.
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH

`define EEP_MCLK_NS 25
`define EEP_WRITE_TIME_NS 5000000
`define EEP_TIMER_W 24
`define EEP_SLAVE_ADDR 7'h50
`define EEP_ADDR_W 9
`define EEP_PAGE_W 6
`define EEP_OFS_W 3
`define EEP_PAGE_BYTES 8
`define EEP_ARRAY_BYTES 512
`define EEP_BYTE_BITS 4'h8
`define EEP_RW_READ 1'h1
`define EEP_HI_ADDR_BIT 0
`define EEP_CNT_ZERO 4'h0
`define EEP_CNT_ONE 4'h1

`endif

// >>> src/eep_pkg.sv
// Purpose: Types for the serial EEPROM slave.
// Assumes: eep_map.svh supplies the address, page and timer widths; byte and state widths are fixed here.
// Notes: State of each module is one packed struct.
`include "eep_map.svh"

package eep_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_HI, ST_LO, ST_DATA, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
   } eep_state_t;

   typedef logic [7:0] eep_byte_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      eep_state_t st;
      eep_state_t nxt;
      logic [3:0] bit_cnt;
      eep_byte_t shreg;
      logic [`EEP_ADDR_W-1:0] addr;
      logic wrote;
      logic mack_ok;
      logic busy;
      logic [`EEP_TIMER_W-1:0] timer;
      logic sda_out;
      logic sda_oe_n;
      logic load;
      logic clear;
      logic commit;
   } eep_top_state_t;

   typedef struct packed {
      logic [`EEP_ARRAY_BYTES-1:0][7:0] mem;
      logic [`EEP_PAGE_BYTES-1:0][7:0] page_buf;
      logic [`EEP_PAGE_BYTES-1:0] valid;
      logic [`EEP_PAGE_W-1:0] page;
      eep_byte_t rd_data;
   } eep_array_state_t;

endpackage : eep_pkg

// >>> src/eep_array.sv
// Purpose: Byte array with one-page write buffer for the EEPROM slave.
// Assumes: load, clear and commit are one-cycle pulses from the bus logic.
// Notes: Array in flip-flops; read data registered one cycle after rd_addr.
`timescale 1ns/100ps
`include "eep_map.svh"

module eep_array (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clear,
   input wire logic load,
   input wire logic [`EEP_ADDR_W-1:0] load_addr,
   input wire eep_pkg::eep_byte_t load_data,
   input wire logic commit,
   input wire logic [`EEP_ADDR_W-1:0] rd_addr,
   output eep_pkg::eep_byte_t rd_data
);

   eep_pkg::eep_array_state_t s_reg;
   eep_pkg::eep_array_state_t s_next;
   logic [`EEP_PAGE_BYTES-1:0][`EEP_ADDR_W-1:0] slot_addr;

   // Every buffered slot maps into the one page latched by the latest load
   genvar g;
   generate
      for (g = 0; g < `EEP_PAGE_BYTES; g++) begin : g_slot
         assign slot_addr[g] = {s_reg.page, `EEP_OFS_W'(g)};
      end
   endgenerate

   always_comb begin
      s_next = s_reg;
      s_next.rd_data = s_reg.mem[rd_addr];
      if (clear) begin
         s_next.valid = '0;
      end
      if (load) begin
         // Later byte for the same slot simply overwrites the earlier one [R06]
         s_next.page_buf[load_addr[`EEP_OFS_W-1:0]] = load_data;
         s_next.valid[load_addr[`EEP_OFS_W-1:0]] = 1'b1;
         s_next.page = load_addr[`EEP_ADDR_W-1:`EEP_OFS_W];
      end
      if (commit) begin
         for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
            if (s_reg.valid[i]) begin
               s_next.mem[slot_addr[i]] = s_reg.page_buf[i];
            end
         end
         s_next.valid = '0;
      end
   end

   // Array keeps its contents over reset, like the real cells
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_reg.page_buf <= '0;
         s_reg.valid <= '0;
         s_reg.page <= '0;
         s_reg.rd_data <= '0;
         s_reg.mem <= s_next.mem;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rd_data = s_reg.rd_data;

endmodule : eep_array

// >>> src/eep_slave.sv
// Purpose: Two-wire bus slave for a 512-byte serial EEPROM with page write.
// Assumes: scl and sda come from the shared bus pins, asynchronous to mclk.
// Notes: Open-drain sda: sda_out is always 0, sda_oe_n low pulls the line low.
//
// Summary of operation
// [R01] After the slave address come two address bytes, upper then lower, each MSB first, assembled in that order.
// [R02] Write data bytes arrive MSB first and are shifted in that order.
// [R03] The bit after the seven address bits is 0 for a write and 1 for a read.
// [R04] Each received data byte advances the address, and one page holds at most eight bytes.
// [R05] The three low address bits wrap from the page end to its start, upper bits unchanged.
// [R06] If wrap sends several bytes to one location, only the last one is kept.
// [R07] A stop condition ends data reception and starts the timed write of the buffered page.
// [R08] The master polls with a start and its address byte with direction 0 during the write.
// [R09] A polling address byte gets no acknowledge while the write runs, and an acknowledge after.
// [R10] Busy shows only once data was received and the stop has arrived.
// [R11] The bus is shared, so the slave answers only its own address and otherwise stays off the line.
// [R12] The receiver acknowledges on the ninth clock; the slave acknowledges its address, both address bytes and data.
// [R13] Only the nine address bits that select a byte are used; the higher bits are ignored.
`timescale 1ns/100ps
`include "eep_map.svh"

module eep_slave #(
   parameter logic [6:0] SLAVE_ADDR = `EEP_SLAVE_ADDR,
   parameter int WRITE_TIME_NS = `EEP_WRITE_TIME_NS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic write_busy
);

   localparam int WRITE_CYCLES_INT = (WRITE_TIME_NS + `EEP_MCLK_NS - 1) / `EEP_MCLK_NS;
   localparam logic [`EEP_TIMER_W-1:0] WRITE_CYCLES =
      (WRITE_CYCLES_INT < 1) ? `EEP_TIMER_W'(1) : `EEP_TIMER_W'(WRITE_CYCLES_INT);

   eep_pkg::eep_top_state_t s_reg;
   eep_pkg::eep_top_state_t s_next;
   eep_pkg::eep_byte_t rd_data;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   eep_pkg::eep_byte_t rx_byte;

   always_comb begin
      scl_rise = s_reg.scl_s2 & ~s_reg.scl_d;
      scl_fall = ~s_reg.scl_s2 & s_reg.scl_d;
      start_seen = s_reg.scl_s2 & s_reg.scl_d & s_reg.sda_d & ~s_reg.sda_s2;
      stop_seen = s_reg.scl_s2 & s_reg.scl_d & ~s_reg.sda_d & s_reg.sda_s2;
      rx_byte = s_reg.shreg;
   end

   always_comb begin
      s_next = s_reg;
      s_next.scl_s1 = scl;
      s_next.scl_s2 = s_reg.scl_s1;
      s_next.scl_d = s_reg.scl_s2;
      s_next.sda_s1 = sda_in;
      s_next.sda_s2 = s_reg.sda_s1;
      s_next.sda_d = s_reg.sda_s2;
      s_next.load = 1'b0;
      s_next.clear = 1'b0;
      s_next.commit = 1'b0;
      s_next.sda_out = 1'b0;

      if (s_reg.busy) begin
         if (s_reg.timer <= `EEP_TIMER_W'(1)) begin
            s_next.busy = 1'b0;
            s_next.commit = 1'b1;
            s_next.timer = '0;
         end else begin
            s_next.timer = s_reg.timer - `EEP_TIMER_W'(1);
         end
      end

      // Advance only after the array has taken the byte at the old address [R04]
      if (s_reg.load) begin
         // Wrap inside the page [R05]
         s_next.addr = {s_reg.addr[`EEP_ADDR_W-1:`EEP_OFS_W],
                        s_reg.addr[`EEP_OFS_W-1:0] + `EEP_OFS_W'(1)};
      end

      if (start_seen) begin
         s_next.st = eep_pkg::ST_ADDR;
         s_next.bit_cnt = `EEP_CNT_ZERO;
         s_next.sda_oe_n = 1'b1;
         s_next.wrote = 1'b0;
      end else if (stop_seen) begin
         s_next.st = eep_pkg::ST_IDLE;
         s_next.sda_oe_n = 1'b1;
         if (s_reg.wrote) begin
            s_next.busy = 1'b1; // [R07] [R10]
            s_next.timer = WRITE_CYCLES;
            s_next.wrote = 1'b0;
         end
      end else begin
         case (s_reg.st)
            eep_pkg::ST_ADDR, eep_pkg::ST_HI, eep_pkg::ST_LO, eep_pkg::ST_DATA: begin
               if (scl_rise && s_reg.bit_cnt != `EEP_BYTE_BITS) begin
                  s_next.shreg = {s_reg.shreg[6:0], s_reg.sda_s2}; // [R01] [R02]
                  s_next.bit_cnt = s_reg.bit_cnt + `EEP_CNT_ONE;
               end else if (scl_fall && s_reg.bit_cnt == `EEP_BYTE_BITS) begin
                  s_next.bit_cnt = `EEP_CNT_ZERO;
                  s_next.st = eep_pkg::ST_ACK;
                  s_next.sda_oe_n = 1'b0; // [R12]
                  case (s_reg.st)
                     eep_pkg::ST_ADDR: begin
                        if (rx_byte[7:1] != SLAVE_ADDR || s_reg.busy) begin
                           // Foreign address, or polling during the write [R11] [R09] [R08]
                           s_next.st = eep_pkg::ST_IGNORE;
                           s_next.sda_oe_n = 1'b1;
                        end else if (rx_byte[0] == `EEP_RW_READ) begin
                           s_next.nxt = eep_pkg::ST_TX; // [R03]
                        end else begin
                           s_next.nxt = eep_pkg::ST_HI;
                           s_next.clear = 1'b1;
                        end
                     end
                     eep_pkg::ST_HI: begin
                        // Upper bits beyond the array size are dropped [R13] [R01]
                        s_next.addr[`EEP_ADDR_W-1] = rx_byte[`EEP_HI_ADDR_BIT];
                        s_next.nxt = eep_pkg::ST_LO;
                     end
                     eep_pkg::ST_LO: begin
                        s_next.addr[7:0] = rx_byte; // [R01]
                        s_next.nxt = eep_pkg::ST_DATA;
                     end
                     default: begin
                        s_next.load = 1'b1; // [R04]
                        s_next.wrote = 1'b1;
                        s_next.nxt = eep_pkg::ST_DATA;
                     end
                  endcase
               end
            end
            eep_pkg::ST_ACK: begin
               if (scl_fall) begin
                  s_next.st = s_reg.nxt;
                  s_next.sda_oe_n = 1'b1;
                  if (s_reg.nxt == eep_pkg::ST_TX) begin
                     s_next.sda_oe_n = rd_data[7];
                     s_next.shreg = {rd_data[6:0], 1'b1};
                     s_next.bit_cnt = `EEP_CNT_ONE;
                  end
               end
            end
            eep_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (s_reg.bit_cnt == `EEP_BYTE_BITS) begin
                     // Release for the master's acknowledge
                     s_next.sda_oe_n = 1'b1;
                     s_next.st = eep_pkg::ST_MACK;
                     s_next.mack_ok = 1'b0;
                     s_next.addr = s_reg.addr + `EEP_ADDR_W'(1);
                  end else begin
                     s_next.sda_oe_n = s_reg.shreg[7];
                     s_next.shreg = {s_reg.shreg[6:0], 1'b1};
                     s_next.bit_cnt = s_reg.bit_cnt + `EEP_CNT_ONE;
                  end
               end
            end
            eep_pkg::ST_MACK: begin
               if (scl_rise) begin
                  s_next.mack_ok = ~s_reg.sda_s2;
               end else if (scl_fall) begin
                  if (s_reg.mack_ok) begin
                     s_next.st = eep_pkg::ST_TX;
                     s_next.sda_oe_n = rd_data[7];
                     s_next.shreg = {rd_data[6:0], 1'b1};
                     s_next.bit_cnt = `EEP_CNT_ONE;
                  end else begin
                     // No acknowledge ends the read; wait for stop
                     s_next.st = eep_pkg::ST_IGNORE;
                  end
               end
            end
            eep_pkg::ST_IDLE, eep_pkg::ST_IGNORE: begin
               s_next.sda_oe_n = 1'b1; // [R11]
            end
            default: begin
               s_next.st = eep_pkg::ST_IDLE;
               s_next.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.scl_s1 <= 1'b1;
         s_reg.scl_s2 <= 1'b1;
         s_reg.scl_d <= 1'b1;
         s_reg.sda_s1 <= 1'b1;
         s_reg.sda_s2 <= 1'b1;
         s_reg.sda_d <= 1'b1;
         s_reg.sda_oe_n <= 1'b1;
         s_reg.st <= eep_pkg::ST_IDLE;
         s_reg.nxt <= eep_pkg::ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // Address held at the page being filled; read data follows addr
   eep_array u_array (
      .mclk(mclk),
      .reset(reset),
      .clear(s_reg.clear),
      .load(s_reg.load),
      .load_addr(s_reg.addr),
      .load_data(s_reg.shreg),
      .commit(s_reg.commit),
      .rd_addr(s_reg.addr),
      .rd_data(rd_data)
   );

   assign sda_out = s_reg.sda_out;
   assign sda_oe_n = s_reg.sda_oe_n;
   assign write_busy = s_reg.busy;

endmodule : eep_slave

// >>> testbench/eep_slave_assertions.sv
// Purpose: Protocol checks on the EEPROM slave pins.
// Assumes: Bound to eep_slave; a single mclk domain.
// Notes: Stop is taken from raw pins, ahead of the slave's synchroniser.
`timescale 1ns/100ps
module eep_slave_assertions #(
   parameter int WRITE_TIME_NS = 5000000
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic write_busy
);
   localparam int WC = (WRITE_TIME_NS + 24) / 25;
   logic [23:0] busy_cnt;
   logic [7:0] since_stop;
   logic sda_d;
   always_ff @(posedge mclk) begin
      sda_d <= sda_in;
      if (reset || !write_busy) begin
         busy_cnt <= 24'h00_0000;
      end else begin
         busy_cnt <= busy_cnt + 24'h00_0001;
      end
      if (reset || (scl && sda_in && !sda_d)) begin
         since_stop <= 8'h00;
      end else if (since_stop != 8'hff) begin
         since_stop <= since_stop + 8'h01;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence ack_held;
      !sda_oe_n [*4];
   endsequence
   sequence oe_quiet;
      $stable(sda_oe_n) [*3];
   endsequence
   chk_drive_zero: assert property (!sda_oe_n |-> !sda_out)
      else $error("sda driven high");
   chk_reset_idle: assert property ($fell(reset) |-> sda_oe_n && !write_busy)
      else $error("outputs not idle after reset");
   chk_busy_length: assert property ($fell(write_busy) |-> busy_cnt == 24'(WC))
      else $error("write time wrong");
   chk_busy_after_stop: assert property ($rose(write_busy) |-> scl && since_stop <= 8'h08)
      else $error("busy without a stop");
   chk_busy_no_ack: assert property (write_busy && $past(write_busy) |-> sda_oe_n)
      else $error("slave drives while busy");
   chk_ack_hold: assert property ($fell(sda_oe_n) |-> ack_held)
      else $error("pull-down too short");
   chk_ack_release: assert property ($fell(sda_oe_n) |-> ##[4:80] $rose(sda_oe_n))
      else $error("pull-down never released");
   chk_scl_high_quiet: assert property ($rose(scl) |=> oe_quiet)
      else $error("sda drive moved while scl high");
endmodule : eep_slave_assertions

bind eep_slave eep_slave_assertions #(.WRITE_TIME_NS(WRITE_TIME_NS)) eep_slave_assertions_i (.mclk(mclk),
   .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_busy(write_busy));

// >>> testbench/eep_master.sv
// Purpose: Bus master model driving the EEPROM slave pins.
// Assumes: 200 ns bit time, eight mclk per bit.
// Notes: sda_m high means released; the bench adds the pull-up.
`timescale 1ns/100ps
module eep_master (
   input wire logic mclk,
   input wire logic sda,
   output logic scl,
   output logic sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // SDA moves mid low phase, far from both SCL edges
   task automatic bit_x(input logic b, output logic r);
      tick(2);
      sda_m <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      r = sda;
      scl <= 1'b0;
   endtask : bit_x
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(mack, ack);
   endtask : xfer
   task automatic start_c;
      tick(2);
      sda_m <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask : start_c
   // SCL then stays high: the bus clock stands still between frames
   task automatic stop_c;
      tick(2);
      sda_m <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b1;
      tick(4);
   endtask : stop_c
endmodule : eep_master

// >>> testbench/eep_slave_tb.sv
// Purpose: Self-checking bench for the EEPROM slave page write.
// Assumes: Write time shortened to 8000 ns, 320 mclk.
// Notes: Model array holds -1 where nothing was written.
`timescale 1ns/100ps
module eep_slave_tb;
   localparam logic [6:0] SADDR = 7'h50;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic scl, sda_m, sda_out, sda_oe_n, write_busy;
   wire logic sda;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int mem_m [512];
   assign sda = sda_m & (sda_oe_n | sda_out);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   eep_slave #(.SLAVE_ADDR(SADDR), .WRITE_TIME_NS(8000)) eep_slave_i (.mclk(mclk), .reset(reset), .scl(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .write_busy(write_busy));
   eep_master eep_master_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_m(sda_m));
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict
   task automatic send(input logic [7:0] d, input logic exp_ack, input string what);
      logic [7:0] q;
      logic a;
      eep_master_i.xfer(d, 1'b1, q, a);
      check(what, {8'h00, exp_ack}, {8'h00, a});
   endtask : send
   task automatic set_addr(input logic [8:0] a);
      eep_master_i.start_c();
      send({SADDR, 1'b0}, 1'b0, "address ack");
      send({7'($urandom), a[8]}, 1'b0, "high byte ack");
      send(a[7:0], 1'b0, "low byte ack");
   endtask : set_addr
   task automatic wr_rd(input logic [8:0] a, input int n);
      logic [7:0] d;
      logic [7:0] q;
      logic k;
      set_addr(a);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         mem_m[{a[8:3], 3'(a[2:0] + i)}] = d;
         send(d, 1'b0, "data ack");
      end
      check("busy before stop", 9'h000, {8'h00, write_busy});
      eep_master_i.stop_c();
      eep_master_i.tick(4);
      check("busy after stop", 9'h001, {8'h00, write_busy});
      eep_master_i.start_c();
      send({SADDR, 1'b0}, 1'b1, "poll while busy");
      eep_master_i.stop_c();
      for (int w = 0; w < 400 && write_busy !== 1'b0; w++) eep_master_i.tick(1);
      check("busy cleared", 9'h000, {8'h00, write_busy});
      eep_master_i.start_c();
      send({SADDR ^ 7'h01, 1'b0}, 1'b1, "foreign address");
      eep_master_i.start_c();
      send({SADDR, 1'b0}, 1'b0, "poll when done");
      eep_master_i.stop_c();
      set_addr({a[8:3], 3'h0});
      eep_master_i.start_c();
      send({SADDR, 1'b1}, 1'b0, "read address ack");
      for (int i = 0; i < 8; i++) begin
         eep_master_i.xfer(8'hff, 1'(i == 7), q, k);
         if (mem_m[{a[8:3], 3'(i)}] >= 0) check("read data", 9'(mem_m[{a[8:3], 3'(i)}]), {1'b0, q});
      end
      eep_master_i.stop_c();
      eep_master_i.tick(8);
      check("busy after read", 9'h000, {8'h00, write_busy});
   endtask : wr_rd
   initial begin
      void'($urandom(32'h5259));
      foreach (mem_m[i]) mem_m[i] = -1;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      eep_master_i.tick(3);
      // Full page first, so no read-back ever meets unwritten cells
      wr_rd(9'h0f0, 8);
      $display("test full page done");
      wr_rd(9'h0f7, 1);
      $display("test page end done");
      wr_rd(9'h10d, 10);
      $display("test page wrap done");
      give_verdict();
   end
   // Three tests need about 6300 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
endmodule : eep_slave_tb
